// ### inc/gref_pkg.sv
// Shared constants and types of the gamma reference serial slave control
package gref_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned LOAD_TIME_US = 560;
  localparam int unsigned LOAD_CYC_DEF = LOAD_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned BANK_SW_TIME_US = 10;
  localparam int unsigned BANK_SW_CYC = BANK_SW_TIME_US * (CLK_HZ / 1_000_000);

  // ----------------------------------------------------------------
  // Channels and codes
  // ----------------------------------------------------------------
  localparam int NUM_GAMMA = 8;
  localparam int NUM_CHAN = 9;
  localparam int COM_IDX = 8;
  localparam int CODE_W = 10;
  localparam logic [9:0] MIDSCALE = 10'h200;
  localparam logic [4:0] NV_WRITE_MAX = 5'h10;

  // ----------------------------------------------------------------
  // Bus codes
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_UPPER = 6'h3a;
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [7:0] GC_RESET_CMD = 8'h06;
  localparam logic [4:0] HS_MASTER_CODE = 5'h01;

  // Data word: update flag in bit 15, code in low ten bits
  typedef struct packed {
    logic update;
    logic [4:0] unused;
    logic [9:0] code;
  } gref_word_t;

  // Pointer byte: bit 7 also stores to nonvolatile bank, low nibble channel
  typedef struct packed {
    logic to_nv;
    logic [2:0] unused;
    logic [3:0] chan;
  } gref_ptr_t;

  typedef enum {ST_IDLE, ST_RX, ST_ACK, ST_SKIP} gref_state_t;
  typedef enum {K_ADDR, K_GC, K_PTR, K_HI, K_LO} gref_kind_t;

  // Master code test, low three bits free
  function automatic logic gref_is_hs(input logic [7:0] b);
    gref_is_hs = (b[7:3] == HS_MASTER_CODE);
  endfunction

  // Own address with write direction
  function automatic logic gref_own_wr(input logic [7:0] b, input logic lsb);
    gref_own_wr = (b[7:2] == ADDR_UPPER) && (b[1] == lsb) && !b[0];
  endfunction

endpackage

// ### rtl/gref_serial_slave_ctrl.sv
// Two-wire slave control of the gamma and common-voltage reference
`timescale 1ns/1ns
`default_nettype none

module gref_serial_slave_ctrl
  import gref_pkg::*;
#(
  parameter int unsigned LOAD_CYCLES = LOAD_CYC_DEF
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_drive_n_o,
  input wire logic addr_lsb_select_pin_i,
  input wire logic bank_choice_pin_i,
  output logic [NUM_GAMMA-1:0][CODE_W-1:0] gamma_outputs_o,
  output logic [CODE_W-1:0] common_voltage_output_o,
  output logic hs_filter_en_o,
  output logic load_busy_o
);

  localparam int LCW = $clog2(LOAD_CYCLES + 1);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic scl_m_q, scl_s_q, scl_p_q;
  logic sda_m_q, sda_s_q, sda_p_q;
  logic strap_m_q, strap_s_q;
  logic bank_m_q, bank_s_q, bank_p_q;
  logic rise_w, fall_w, start_w, stop_w, eval_w, bank_chg_w;
  logic irst_w;
  logic gc_fire_q, gc_pend_q;
  gref_state_t state_q;
  gref_kind_t kind_q, kind_d;
  logic [7:0] sh_q;
  logic [3:0] cnt_q;
  logic skip_q, skip_d, ack_d, gc_hit_d;
  gref_ptr_t ptr_q;
  logic [7:0] hi_q;
  gref_word_t word_w;
  logic chan_ok_w, wr_w, nv_wr_w;
  logic [LCW-1:0] load_cnt_q;
  logic load_done_w;
  logic [CODE_W-1:0] nv_q [2][NUM_CHAN];
  logic [4:0] nv_cnt_q [2][NUM_CHAN];
  logic [CODE_W-1:0] store_q [2][NUM_CHAN];
  logic [CODE_W-1:0] inbuf_q [NUM_CHAN];
  logic [NUM_CHAN-1:0][CODE_W-1:0] dac_q;

  // ----------------------------------------------------------------
  // Pin synchronisers and line events
  // ----------------------------------------------------------------
  // Two flops per pin, third flop on clock, data and bank keeps the previous settled level
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
      {bank_m_q, bank_s_q, bank_p_q} <= 3'h0;
      {strap_m_q, strap_s_q} <= 2'h0;
    end else begin
      {scl_m_q, scl_s_q, scl_p_q} <= {scl_i, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {sda_i, sda_m_q, sda_s_q};
      {bank_m_q, bank_s_q, bank_p_q} <= {bank_choice_pin_i, bank_m_q, bank_s_q};
      {strap_m_q, strap_s_q} <= {addr_lsb_select_pin_i, strap_m_q};
    end
  end

  // Clock is only ever sampled, there is no driver for it
  assign rise_w = scl_s_q && !scl_p_q;
  assign fall_w = !scl_s_q && scl_p_q;
  // Data edges with clock high are framing conditions
  assign start_w = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
  assign stop_w = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;
  assign eval_w = fall_w && (state_q == ST_RX) && (cnt_q == 4'h8);
  assign bank_chg_w = bank_s_q != bank_p_q;

  // General call restarts the block like a power cycle, except the pin synchronisers and nonvolatile words
  assign irst_w = rst_i || gc_fire_q;

  // ----------------------------------------------------------------
  // Byte decision
  // ----------------------------------------------------------------
  // Decides acknowledge and what the next byte means
  always_comb begin
    ack_d = 1'b0;
    skip_d = 1'b1;
    kind_d = kind_q;
    gc_hit_d = 1'b0;
    case (kind_q)
      K_ADDR: begin
        if (load_busy_o) begin
          ack_d = 1'b0;
        end else if (gref_own_wr(sh_q, strap_s_q)) begin
          ack_d = 1'b1;
          skip_d = 1'b0;
          kind_d = K_PTR;
        end else if (sh_q == GC_ADDR) begin
          ack_d = 1'b1;
          skip_d = 1'b0;
          kind_d = K_GC;
        end
        // Master code and foreign addresses leave the line released
      end
      K_GC: begin
        if (sh_q == GC_RESET_CMD) begin
          ack_d = 1'b1;
          gc_hit_d = 1'b1;
        end
      end
      K_PTR: begin
        ack_d = 1'b1;
        skip_d = 1'b0;
        kind_d = K_HI;
      end
      K_HI: begin
        ack_d = 1'b1;
        skip_d = 1'b0;
        kind_d = K_LO;
      end
      K_LO: begin
        ack_d = 1'b1;
        skip_d = 1'b0;
        kind_d = K_HI;
      end
      default: begin
        ack_d = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Bus state machine
  // ----------------------------------------------------------------
  // Shifts bits on rising clock, drives acknowledge through the ninth bit
  always_ff @(posedge clk_sys_i) begin
    if (irst_w) begin
      state_q <= ST_IDLE;
      kind_q <= K_ADDR;
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
      skip_q <= 1'b0;
      gc_pend_q <= 1'b0;
      ptr_q <= '0;
      hi_q <= 8'h00;
      sda_drive_n_o <= 1'b1;
    end else if (start_w) begin
      state_q <= ST_RX;
      kind_q <= K_ADDR;
      cnt_q <= 4'h0;
      sda_drive_n_o <= 1'b1;
    end else if (stop_w) begin
      state_q <= ST_IDLE;
      sda_drive_n_o <= 1'b1;
    end else begin
      case (state_q)
        ST_RX: begin
          if (rise_w) begin
            sh_q <= {sh_q[6:0], sda_s_q};
            cnt_q <= cnt_q + 4'h1;
          end else if (eval_w) begin
            sda_drive_n_o <= !ack_d;
            kind_q <= kind_d;
            skip_q <= skip_d;
            gc_pend_q <= gc_hit_d;
            state_q <= ST_ACK;
            if (kind_q == K_PTR) begin
              ptr_q <= sh_q;
            end
            if (kind_q == K_HI) begin
              hi_q <= sh_q;
            end
            if (kind_q == K_LO) begin
              ptr_q.chan <= ptr_q.chan + 4'h1; // Auto-increment
            end
          end
        end
        ST_ACK: begin
          if (fall_w) begin
            sda_drive_n_o <= 1'b1;
            cnt_q <= 4'h0;
            state_q <= skip_q ? ST_SKIP : ST_RX;
          end
        end
        ST_SKIP, ST_IDLE: begin
          sda_drive_n_o <= 1'b1;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Reset fires once the acknowledge of the command byte is over
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      gc_fire_q <= 1'b0;
    end else begin
      gc_fire_q <= gc_pend_q && (state_q == ST_ACK) && fall_w && !gc_fire_q;
    end
  end

  // The line is only ever pulled low; the enable carries the data
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // High-speed mode
  // ----------------------------------------------------------------
  // Set by master code, kept over repeated START, cleared at STOP
  always_ff @(posedge clk_sys_i) begin
    if (irst_w) begin
      hs_filter_en_o <= 1'b0;
    end else if (stop_w) begin
      hs_filter_en_o <= 1'b0;
    end else if (eval_w && kind_q == K_ADDR && gref_is_hs(sh_q)) begin
      hs_filter_en_o <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Power-on bank load
  // ----------------------------------------------------------------
  // Counts the nonvolatile read time after any reset
  always_ff @(posedge clk_sys_i) begin
    if (irst_w) begin
      load_busy_o <= 1'b1;
      load_cnt_q <= '0;
    end else if (load_busy_o) begin
      if (load_done_w) begin
        load_busy_o <= 1'b0;
      end else begin
        load_cnt_q <= load_cnt_q + LCW'(1);
      end
    end
  end

  assign load_done_w = load_busy_o && (load_cnt_q == LCW'(LOAD_CYCLES - 1));

  // ----------------------------------------------------------------
  // Channel words
  // ----------------------------------------------------------------
  assign word_w = {hi_q, sh_q};
  assign chan_ok_w = ptr_q.chan < 4'(NUM_CHAN);
  assign wr_w = eval_w && (kind_q == K_LO) && chan_ok_w && !load_busy_o;
  assign nv_wr_w = wr_w && ptr_q.to_nv && (nv_cnt_q[bank_s_q][ptr_q.chan] < NV_WRITE_MAX);

  // Nonvolatile words with wear counters, untouched by general call
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      for (int b = 0; b < 2; b++) begin
        for (int c = 0; c < NUM_CHAN; c++) begin
          nv_q[b][c] <= MIDSCALE;
          nv_cnt_q[b][c] <= 5'h00;
        end
      end
    end else if (nv_wr_w) begin
      nv_q[bank_s_q][ptr_q.chan] <= word_w.code;
      nv_cnt_q[bank_s_q][ptr_q.chan] <= nv_cnt_q[bank_s_q][ptr_q.chan] + 5'h01;
    end
  end

  // Two storage registers per channel, one for each bank
  always_ff @(posedge clk_sys_i) begin
    if (irst_w) begin
      for (int b = 0; b < 2; b++) begin
        for (int c = 0; c < NUM_CHAN; c++) begin
          store_q[b][c] <= MIDSCALE;
        end
      end
    end else if (load_done_w) begin
      store_q <= nv_q;
    end else if (nv_wr_w) begin
      store_q[bank_s_q][ptr_q.chan] <= word_w.code;
    end
  end

  // Input buffer holds written words until an update
  always_ff @(posedge clk_sys_i) begin
    if (irst_w) begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        inbuf_q[c] <= MIDSCALE;
      end
    end else if (wr_w) begin
      inbuf_q[ptr_q.chan] <= word_w.code;
    end
  end

  // ----------------------------------------------------------------
  // Converter codes
  // ----------------------------------------------------------------
  // Midscale at reset, bank after load, bank pin switch, bus update
  always_ff @(posedge clk_sys_i) begin
    if (irst_w) begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        dac_q[c] <= MIDSCALE;
      end
    end else if (load_done_w) begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        dac_q[c] <= nv_q[bank_s_q][c];
      end
    end else if (bank_chg_w && !load_busy_o) begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        dac_q[c] <= store_q[bank_s_q][c];
      end
    end else if (wr_w && word_w.update) begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        dac_q[c] <= (4'(c) == ptr_q.chan) ? word_w.code : inbuf_q[c];
      end
    end
  end

  assign gamma_outputs_o = dac_q[NUM_GAMMA-1:0];
  assign common_voltage_output_o = dac_q[COM_IDX];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (irst_w);

  AST_OWN_ACK: assert property (eval_w && kind_q == K_ADDR && !load_busy_o && gref_own_wr(sh_q, strap_s_q)
    |=> !sda_drive_n_o) else $error("own address not acknowledged");
  AST_ACK_HOLD: assert property (!sda_drive_n_o && !fall_w && !start_w && !stop_w |=> !sda_drive_n_o)
    else $error("acknowledge dropped early");
  AST_HS_NO_ACK: assert property (eval_w && kind_q == K_ADDR && gref_is_hs(sh_q)
    |=> sda_drive_n_o && hs_filter_en_o) else $error("master code acknowledged or not taken");
  AST_HS_STOP: assert property (stop_w |=> !hs_filter_en_o) else $error("high speed kept past stop");
  AST_HS_RSTART: assert property (hs_filter_en_o && start_w && !stop_w |=> hs_filter_en_o)
    else $error("high speed lost at repeated start");
  AST_GC_NACK: assert property (eval_w && kind_q == K_GC && sh_q != GC_RESET_CMD
    |=> sda_drive_n_o) else $error("bad general call data acknowledged");
  AST_GC_ACK: assert property (eval_w && kind_q == K_GC && sh_q == GC_RESET_CMD
    |=> !sda_drive_n_o && gc_pend_q) else $error("general call reset not acknowledged");
  AST_MIDSCALE: assert property (disable iff (rst_i) gc_fire_q |=> load_busy_o &&
    dac_q[0] == MIDSCALE && common_voltage_output_o == MIDSCALE) else $error("reset not midscale");
  AST_LOAD_APPLY: assert property (load_done_w |=> dac_q[0] == $past(nv_q[bank_s_q][0]) &&
    dac_q[COM_IDX] == $past(nv_q[bank_s_q][COM_IDX]) && !load_busy_o) else $error("bank not applied");
  AST_BUSY_NACK: assert property (load_busy_o && eval_w && kind_q == K_ADDR |=> sda_drive_n_o)
    else $error("bus answered during load");
  AST_BANK_SW: assert property (bank_chg_w && !load_busy_o |=> dac_q[0] == $past(store_q[bank_s_q][0]) &&
    dac_q[COM_IDX] == $past(store_q[bank_s_q][COM_IDX])) else $error("bank switch not applied");
  AST_UPDATE: assert property (wr_w && word_w.update && !bank_chg_w
    |=> dac_q[$past(ptr_q.chan)] == $past(word_w.code)) else $error("update word not applied");
  AST_HOLD: assert property (wr_w && !word_w.update && !bank_chg_w |=> $stable(dac_q))
    else $error("held word reached outputs");
  AST_WEAR: assert property (nv_cnt_q[bank_s_q][0] <= NV_WRITE_MAX) else $error("write count over bound");

  COV_GC_RESET: cover property (gc_fire_q);
  COV_HS_ENTRY: cover property ($rose(hs_filter_en_o));
  COV_UPDATE: cover property (wr_w && word_w.update);
  COV_BANK_SW: cover property (bank_chg_w && !load_busy_o);

endmodule

`default_nettype wire

// ### bench/gref_bus_master.sv
// Two-wire bus master model that drives the block's serial clock and data pins
`timescale 1ns/1ns
`default_nettype none

module gref_bus_master (
  input wire logic clk_sys_i,
  input wire logic sda_line_i,
  output logic scl_o,
  output logic sda_low_o
);
  // ----------------------------------------------------------------
  // Idle bus: clock stands high, data released to the pull-up
  // ----------------------------------------------------------------
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  // Half of the 160 ns bus clock period, four system clocks
  task automatic half();
    repeat (4) @(negedge clk_sys_i);
  endtask

  // Data is set up one cycle after clock fall, never while clock is high
  task automatic setup_bit(input logic low);
    @(negedge clk_sys_i);
    sda_low_o = low;
    repeat (3) @(negedge clk_sys_i);
  endtask

  // START or repeated START: data falls while clock is high
  task automatic start_cond();
    setup_bit(1'b0);
    scl_o = 1'b1;
    half();
    sda_low_o = 1'b1;
    half();
    scl_o = 1'b0;
  endtask

  // STOP: data rises while clock is high, clock then stands still
  task automatic stop_cond();
    setup_bit(1'b1);
    scl_o = 1'b1;
    half();
    sda_low_o = 1'b0;
    half();
  endtask

  // Eight bits msb first, then a ninth clock that samples the acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      setup_bit(~b[i]);
      scl_o = 1'b1;
      half();
      scl_o = 1'b0;
    end
    setup_bit(1'b0);
    scl_o = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    ack = ~sda_line_i;
    repeat (2) @(negedge clk_sys_i);
    scl_o = 1'b0;
  endtask
endmodule

`default_nettype wire

// ### bench/gamma_ref_serial_slave_ctrl_bench.sv
// Self-checking testbench of the gamma reference serial slave control
`timescale 1ns/1ns
`default_nettype none

module gamma_ref_serial_slave_ctrl_bench
  import gref_pkg::*;
();

  logic clk = 1'b0;
  logic rst, strap, bank, scl, mst_low, drv_n, sda_o_w, hs, busy;
  logic [7:0][9:0] gam;
  logic [9:0] com_v;
  wire sda_line;
  logic [9:0] buf_m[9], out_m[9], nv0[9], nv1[9], codes[9];
  logic [7:0] b;
  logic [3:0] ch;
  int miscompares = 0;
  int comparisons = 0;

  // ----------------------------------------------------------------
  // Clock, wired-AND data line with pull-up, design and master
  // ----------------------------------------------------------------
  initial forever #10 clk = ~clk;
  assign sda_line = !(mst_low || (!drv_n && !sda_o_w));

  gref_serial_slave_ctrl #(.LOAD_CYCLES(300)) dut_u (
    .clk_sys_i(clk), .rst_i(rst), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o_w), .sda_drive_n_o(drv_n), .addr_lsb_select_pin_i(strap),
    .bank_choice_pin_i(bank), .gamma_outputs_o(gam), .common_voltage_output_o(com_v),
    .hs_filter_en_o(hs), .load_busy_o(busy));

  gref_bus_master mst_u (.clk_sys_i(clk), .sda_line_i(sda_line), .scl_o(scl), .sda_low_o(mst_low));

  // Address byte from strap level and direction
  function automatic logic [7:0] addr_byte(input logic lsb, input logic rd);
    return {ADDR_UPPER, lsb, rd};
  endfunction

  // High byte of a word: update flag on top, code bits 9:8 at the bottom
  function automatic logic [7:0] hi_byte(input logic upd, input logic [9:0] code);
    return {upd, 5'h00, code[9:8]};
  endfunction

  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] bt, input logic exp_ack);
    logic ack;
    mst_u.send_byte(bt, ack);
    check("ack", {9'h000, exp_ack}, {9'h000, ack});
  endtask

  task automatic cmp_all(input string what);
    for (int i = 0; i < 9; i++) check(what, out_m[i], (i < 8) ? gam[i] : com_v);
  endtask

  // One addressing transaction; a refused address sees its next byte ignored
  task automatic probe(input logic [7:0] bt, input logic exp_ack);
    mst_u.start_cond();
    wr(bt, exp_ack);
    if (!exp_ack) wr(8'h83, 1'b0);
    mst_u.stop_cond();
  endtask

  task automatic wait_load();
    for (int n = 0; n < 400 && busy !== 1'b0; n++) @(negedge clk);
    check("load_busy", 10'h000, {9'h000, busy});
  endtask

  // All nine channels from pointer 0, update flag only on the last word
  task automatic wr_all(input logic to_nv);
    for (int i = 0; i < 9; i++) codes[i] = 10'($urandom);
    mst_u.start_cond();
    wr(addr_byte(1'b0, 1'b0), 1'b1);
    wr({to_nv, 7'h00}, 1'b1);
    for (int i = 0; i < 9; i++) begin
      wr(hi_byte(i == 8, codes[i]), 1'b1);
      wr(codes[i][7:0], 1'b1);
      buf_m[i] = codes[i];
      if (i == 7) cmp_all("held_outputs");
    end
    mst_u.stop_cond();
    out_m = buf_m;
    if (to_nv) nv0 = codes;
    cmp_all("updated_outputs");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    strap = 1'b0;
    bank = 1'b0;
    void'($urandom(32'hafc839d3));
    for (int i = 0; i < 9; i++) begin
      out_m[i] = MIDSCALE;
      nv0[i] = MIDSCALE;
      nv1[i] = MIDSCALE;
    end
    repeat (4) @(negedge clk);
    check("reset_busy", 10'h001, {9'h000, busy});
    check("reset_release", 10'h001, {9'h000, drv_n});
    cmp_all("midscale");
    rst = 1'b0;
    // Address sent while the bank load still runs
    probe(addr_byte(1'b0, 1'b0), 1'b0);
    wait_load();
    cmp_all("bank_after_load");
    // Own, other-strap and read-direction addresses for both strap levels
    for (int k = 0; k < 2; k++) begin
      strap = k[0];
      repeat (4) @(negedge clk);
      probe(addr_byte(strap, 1'b0), 1'b1);
      probe(addr_byte(~strap, 1'b0), 1'b0);
      probe(addr_byte(strap, 1'b1), 1'b0);
    end
    strap = 1'b0;
    // Random foreign addresses
    for (int k = 0; k < 6; k++) begin
      b = 8'($urandom);
      if (b[7:2] == ADDR_UPPER || b == GC_ADDR || b[7:3] == 5'h01) b = 8'h20;
      probe(b, 1'b0);
    end
    wr_all(1'b0);
    // Single random words with immediate update
    for (int k = 0; k < 5; k++) begin
      ch = 4'($urandom_range(8));
      codes[0] = 10'($urandom);
      mst_u.start_cond();
      wr(addr_byte(1'b0, 1'b0), 1'b1);
      wr({4'h0, ch}, 1'b1);
      wr(hi_byte(1'b1, codes[0]), 1'b1);
      wr(codes[0][7:0], 1'b1);
      buf_m[ch] = codes[0];
      out_m = buf_m;
      cmp_all("single_update");
      mst_u.stop_cond();
    end
    // Store to bank zero, refused general-call data, then general-call reset
    wr_all(1'b1);
    mst_u.start_cond();
    wr(GC_ADDR, 1'b1);
    wr(8'h05, 1'b0);
    mst_u.stop_cond();
    check("no_reset", 10'h000, {9'h000, busy});
    mst_u.start_cond();
    wr(GC_ADDR, 1'b1);
    wr(GC_RESET_CMD, 1'b1);
    mst_u.stop_cond();
    check("gc_reset_busy", 10'h001, {9'h000, busy});
    for (int i = 0; i < 9; i++) out_m[i] = MIDSCALE;
    cmp_all("gc_midscale");
    wait_load();
    out_m = nv0;
    cmp_all("bank_zero_applied");
    bank = 1'b1;
    repeat (20) @(negedge clk);
    out_m = nv1;
    cmp_all("bank_one");
    bank = 1'b0;
    repeat (20) @(negedge clk);
    out_m = nv0;
    cmp_all("bank_zero");
    // Every master code: refused, high-speed on, kept over repeated START
    for (int k = 0; k < 8; k++) begin
      check("hs_before", 10'h000, {9'h000, hs});
      mst_u.start_cond();
      wr({HS_MASTER_CODE, 3'(k)}, 1'b0);
      check("hs_on", 10'h001, {9'h000, hs});
      mst_u.start_cond();
      wr(addr_byte(1'b0, 1'b0), 1'b1);
      check("hs_held", 10'h001, {9'h000, hs});
      mst_u.stop_cond();
      repeat (4) @(negedge clk);
      check("hs_off", 10'h000, {9'h000, hs});
    end
    // Seventeen stores to one word of bank one; the last is over the bound
    bank = 1'b1;
    repeat (20) @(negedge clk);
    out_m = nv1;
    for (int k = 0; k < 17; k++) begin
      codes[0] = 10'($urandom);
      mst_u.start_cond();
      wr(addr_byte(1'b0, 1'b0), 1'b1);
      wr(8'h88, 1'b1);
      wr(hi_byte(1'b0, codes[0]), 1'b1);
      wr(codes[0][7:0], 1'b1);
      mst_u.stop_cond();
      if (k < 16) nv1[8] = codes[0];
    end
    // Word to a channel that does not exist is taken but discarded
    mst_u.start_cond();
    wr(addr_byte(1'b0, 1'b0), 1'b1);
    wr(8'h09, 1'b1);
    wr(hi_byte(1'b1, 10'h155), 1'b1);
    wr(8'h55, 1'b1);
    mst_u.stop_cond();
    cmp_all("stored_not_applied");
    mst_u.start_cond();
    wr(GC_ADDR, 1'b1);
    wr(GC_RESET_CMD, 1'b1);
    mst_u.stop_cond();
    wait_load();
    out_m = nv1;
    cmp_all("wear_bound");
    stop_test();
  end

  // Watchdog well beyond the expected run of about 15000 cycles
  initial begin
    #1000000;
    miscompares++;
    stop_test();
  end
endmodule

`default_nettype wire
